// >>> hw/ctf_defs.svh
// Constants of the telemetry frame formatter: timing, slots, codes and reset values
`ifndef CTF_DEFS_SVH
`define CTF_DEFS_SVH

// ==============================================
// Clock and conversion timing
`define CTF_CLK_PERIOD_NS   100'd10
`define CTF_CONVERT_STROBE_TIME_NS    100'd4000
// Two synchroniser flops, the edge detect and the result register add to the count, hence minus four
`define CTF_CONVERT_STROBE_CYCLES     (((`CTF_CONVERT_STROBE_TIME_NS) / (`CTF_CLK_PERIOD_NS)) - 100'd4)
`define CTF_CONVERT_STROBE_CNT_W      9

// ==============================================
// Frame layout
`define CTF_SLOT_W          5
`define CTF_SLOT_LAST       5'h1f
`define CTF_SLOT_Z_LSB      2'h2
`define CTF_SLOT_PIX_X      5'h03
`define CTF_SLOT_PIX_Y      5'h04
`define CTF_SLOT_NOPIX_X    5'h02
`define CTF_SLOT_NOPIX_Y    5'h03
`define CTF_SLOT_EXPO       5'h1c
`define CTF_SLOT_TYPE       5'h1f

// ==============================================
// Frame type codes (arbitrary values, to be matched with the ground software)
`define CTF_CODE_EMPTY      8'h01
`define CTF_CODE_NOPIX      8'h02
`define CTF_CODE_PIX        8'h03

// ==============================================
// Converter coding and reset values
`define CTF_OFFSET_FLIP     8'h80
`define CTF_DATA_RST        8'h00
`define CTF_ADDR_RST        8'h00
`define CTF_FIFO_DEPTH      16

`endif

// >>> hw/ctf_pkg.sv
// Types shared by the telemetry frame formatter
package ctf_pkg;

   // ==============================================
   // Frame kinds picked at each frame start
   typedef enum logic [2:0] {
      CTF_FRAME_EMPTY = 3'b001,
      CTF_FRAME_NOPIX = 3'b010,
      CTF_FRAME_PIX   = 3'b100
   } ctf_frame_t;

   // ==============================================
   // Converter states
   typedef enum logic [2:0] {
      CTF_CONVERT_STROBE_IDLE = 3'b001,
      CTF_CONVERT_STROBE_RUN  = 3'b010,
      CTF_CONVERT_STROBE_DONE = 3'b100
   } ctf_convert_strobe_state_t;

   // ==============================================
   // Pixel address carried as one unit
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
   } ctf_addr_t;

   // Camera and telemetry control inputs travelling together
   typedef struct packed {
      logic convert;
      logic enable;
      logic window;
      logic frame_start;
      logic word_strobe;
   } ctf_ctrl_t;

endpackage

// >>> hw/ctf_fifo.sv
// Pixel FIFO between converter and frame formatter
`timescale 1ns/1ns
`default_nettype none

module ctf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rstn_in,
   input  wire logic             flush_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);

   localparam int AW = $clog2(DEPTH);

   // ==============================================
   // Storage and pointers; the extra pointer bit tells full from empty
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire              full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire              empty_w = (wr_ptr_reg == rd_ptr_reg);
   wire              push_w  = wr_valid_in && !full_w;
   wire              pop_w   = rd_ready_in && !empty_w;

   assign wr_ready_out = !full_w;
   assign rd_valid_out = !empty_w;
   assign rd_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge ref_clk_in) begin
      if (push_w) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (flush_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> hw/ctf_formatter.sv
// Pixel converter and telemetry frame formatter top
`timescale 1ns/1ns
`default_nettype none
`include "ctf_defs.svh"

// Function
// - Convert each sampled level to 8 bits, starting only on convert strobe.
// - Convert only while conversion enable is high; erase pixels are skipped.
// - Pixel valid flag is high exactly while a valid word sits on the bus.
// - Output coding is offset binary: 00 low, 80 zero, ff top.
// - Each result is ready in under four microseconds after the strobe.
// - Pixel, experiment and telemetry data buses are all eight bits wide.
// - Slots 0 and 1 belong to telemetry; 30 slots carry experiment data.
// - Per pixel frame: eight intensities, two addresses, exposure/filter, frame type.
// - Idle or exposing camera gives an empty frame: type and exposure/filter.
// - Unconverted pixels give a frame addressed at X zero, next line.
// - Active section gives a frame with eight intensities and group address.
// - Frame start pulse from telemetry begins building each new frame.
// - Frame type chosen at frame start from enable and pixel window.
// - Empty frame fills only slot 28 and slot 31; other slots zero.
// - No-pixel frame fills slots 2, 3, 28 and the type word.
// - Each rising word strobe edge within a frame moves the holding register onto the bus.
// - Next word is loaded into the holding register between strobe edges.
// - Pixel-with frames pull pixels with fetch commands paced by word timing.
module ctf_formatter #(
   parameter int FIFO_DEPTH = `CTF_FIFO_DEPTH
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rstn_in,
   input  wire logic       convert_strobe_in,
   input  wire logic       conversion_enable_in,
   input  wire logic       active_pixel_window_in,
   input  wire logic [7:0] sample_level_in,
   input  wire logic [7:0] exposure_filter_in,
   input  wire logic       frame_start_pulse_in,
   input  wire logic       word_strobe_in,
   output logic      [7:0] pixel_data_out,
   output logic            pixel_valid_out,
   output logic            pixel_fetch_cmd_out,
   output logic      [7:0] tlm_data_out,
   output logic            tlm_slot_own_out,
   output logic      [2:0] frame_kind_out
);

   // ==============================================
   // Input synchronisers, all pins pass two flip-flops
   ctf_pkg::ctf_ctrl_t ctrl_meta_reg;
   ctf_pkg::ctf_ctrl_t ctrl_sync_reg;
   ctf_pkg::ctf_ctrl_t ctrl_prev_reg;
   logic [7:0]         level_meta_reg;
   logic [7:0]         level_sync_reg;
   logic [7:0]         expo_meta_reg;
   logic [7:0]         expo_sync_reg;
   ctf_pkg::ctf_ctrl_t ctrl_pins_w;

   assign ctrl_pins_w = '{convert:     convert_strobe_in,
                          enable:      conversion_enable_in,
                          window:      active_pixel_window_in,
                          frame_start: frame_start_pulse_in,
                          word_strobe: word_strobe_in};

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_meta_reg  <= '0;
         ctrl_sync_reg  <= '0;
         ctrl_prev_reg  <= '0;
         level_meta_reg <= `CTF_DATA_RST;
         level_sync_reg <= `CTF_DATA_RST;
         expo_meta_reg  <= `CTF_DATA_RST;
         expo_sync_reg  <= `CTF_DATA_RST;
      end else begin
         ctrl_meta_reg  <= ctrl_pins_w;
         ctrl_sync_reg  <= ctrl_meta_reg;
         ctrl_prev_reg  <= ctrl_sync_reg;
         level_meta_reg <= sample_level_in;
         level_sync_reg <= level_meta_reg;
         expo_meta_reg  <= exposure_filter_in;
         expo_sync_reg  <= expo_meta_reg;
      end
   end

   wire enable_w      = ctrl_sync_reg.enable;
   wire window_w      = ctrl_sync_reg.window;
   wire convert_rise  = ctrl_sync_reg.convert && !ctrl_prev_reg.convert;
   wire frame_rise    = ctrl_sync_reg.frame_start && !ctrl_prev_reg.frame_start;
   wire strobe_rise   = ctrl_sync_reg.word_strobe && !ctrl_prev_reg.word_strobe;
   wire window_fall   = !ctrl_sync_reg.window && ctrl_prev_reg.window;

   // ==============================================
   // Converter
   localparam logic [`CTF_CONVERT_STROBE_CNT_W-1:0] CONVERT_STROBE_LAST = `CTF_CONVERT_STROBE_CNT_W'(`CTF_CONVERT_STROBE_CYCLES);

   ctf_pkg::ctf_convert_strobe_state_t   convert_strobe_state_reg;
   ctf_pkg::ctf_convert_strobe_state_t   convert_strobe_state_next;
   logic [`CTF_CONVERT_STROBE_CNT_W-1:0] convert_strobe_cnt_reg;
   logic [7:0]                 convert_strobe_level_reg;
   logic                       fifo_wr_ready_w;

   // A strobe seen while the last result still waits for the FIFO is dropped, not queued
   wire convert_strobe_start_w = convert_rise && enable_w;
   wire convert_strobe_end_w   = (convert_strobe_state_reg == ctf_pkg::CTF_CONVERT_STROBE_RUN) && (convert_strobe_cnt_reg == CONVERT_STROBE_LAST);
   wire convert_strobe_push_w  = (convert_strobe_state_reg == ctf_pkg::CTF_CONVERT_STROBE_DONE) && fifo_wr_ready_w;
   wire [7:0] coded_w = level_sync_reg ^ `CTF_OFFSET_FLIP;

   always_comb begin
      convert_strobe_state_next = convert_strobe_state_reg;
      case (convert_strobe_state_reg)
         ctf_pkg::CTF_CONVERT_STROBE_IDLE: begin
            if (convert_strobe_start_w) begin
               convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_RUN;
            end
         end
         ctf_pkg::CTF_CONVERT_STROBE_RUN: begin
            if (!enable_w) begin
               convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_IDLE;
            end else if (convert_strobe_end_w) begin
               convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_DONE;
            end
         end
         ctf_pkg::CTF_CONVERT_STROBE_DONE: begin
            if (!enable_w) begin
               convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_IDLE;
            end else if (convert_strobe_push_w) begin
               convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_IDLE;
            end
         end
         default: begin
            convert_strobe_state_next = ctf_pkg::CTF_CONVERT_STROBE_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         convert_strobe_state_reg <= ctf_pkg::CTF_CONVERT_STROBE_IDLE;
         convert_strobe_cnt_reg   <= '0;
         convert_strobe_level_reg <= `CTF_DATA_RST;
      end else begin
         convert_strobe_state_reg <= convert_strobe_state_next;
         if (convert_strobe_state_reg == ctf_pkg::CTF_CONVERT_STROBE_IDLE && convert_strobe_start_w) begin
            convert_strobe_level_reg <= coded_w;
            convert_strobe_cnt_reg   <= '0;
         end else if (convert_strobe_state_reg == ctf_pkg::CTF_CONVERT_STROBE_RUN) begin
            convert_strobe_cnt_reg <= convert_strobe_cnt_reg + 1'b1;
         end
      end
   end

   // Result bus and valid flag: valid rises with the result, falls at the next start or on disable
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pixel_data_out  <= `CTF_DATA_RST;
         pixel_valid_out <= 1'b0;
      end else if (!enable_w || convert_strobe_start_w) begin
         pixel_valid_out <= 1'b0;
      end else if (convert_strobe_end_w) begin
         pixel_data_out  <= convert_strobe_level_reg;
         pixel_valid_out <= 1'b1;
      end
   end

   // ==============================================
   // Pixel FIFO; a full FIFO holds the converter in its done state
   logic       fifo_rd_valid_w;
   logic [7:0] fifo_rd_data_w;
   logic       fifo_pop_w;

   ctf_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .rstn_in      (rstn_in),
      .flush_in     (!enable_w),
      .wr_valid_in  (convert_strobe_state_reg == ctf_pkg::CTF_CONVERT_STROBE_DONE),
      .wr_ready_out (fifo_wr_ready_w),
      .wr_data_in   (convert_strobe_level_reg),
      .rd_valid_out (fifo_rd_valid_w),
      .rd_ready_in  (fifo_pop_w),
      .rd_data_out  (fifo_rd_data_w)
   );

   // ==============================================
   // Pixel position tracking
   logic [7:0] x_count_reg;
   logic [7:0] line_reg;

   // Line counter moves on at the end of each imaged section, so it already names the next line
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         x_count_reg <= `CTF_ADDR_RST;
         line_reg    <= `CTF_ADDR_RST;
      end else if (!enable_w) begin
         x_count_reg <= `CTF_ADDR_RST;
         line_reg    <= `CTF_ADDR_RST;
      end else if (window_fall) begin
         x_count_reg <= `CTF_ADDR_RST;
         line_reg    <= line_reg + 1'b1;
      end else if (fifo_pop_w) begin
         x_count_reg <= x_count_reg + 1'b1;
      end
   end

   // ==============================================
   // Frame sequencing
   ctf_pkg::ctf_frame_t     frame_reg;
   ctf_pkg::ctf_frame_t     frame_next;
   ctf_pkg::ctf_addr_t      addr_reg;
   ctf_pkg::ctf_addr_t      addr_next;
   logic [`CTF_SLOT_W-1:0]  slot_reg;
   logic                    load_pend_reg;
   logic                    frame_done_reg;
   logic [7:0]              hold_reg;

   assign frame_next = (enable_w && window_w) ? ctf_pkg::CTF_FRAME_PIX :
                       enable_w               ? ctf_pkg::CTF_FRAME_NOPIX :
                                                ctf_pkg::CTF_FRAME_EMPTY;
   assign addr_next  = (frame_next == ctf_pkg::CTF_FRAME_PIX) ?
                       ctf_pkg::ctf_addr_t'{x: x_count_reg, y: line_reg} :
                       ctf_pkg::ctf_addr_t'{x: `CTF_ADDR_RST, y: line_reg};

   // Slot decode per frame kind
   wire is_pix_w   = (frame_reg == ctf_pkg::CTF_FRAME_PIX);
   wire is_nopix_w = (frame_reg == ctf_pkg::CTF_FRAME_NOPIX);
   wire own_w      = (slot_reg < `CTF_SLOT_W'(2));
   wire z_slot_w   = is_pix_w && (slot_reg[1:0] == `CTF_SLOT_Z_LSB) && !own_w;
   wire x_slot_w   = (is_pix_w && slot_reg == `CTF_SLOT_PIX_X) ||
                     (is_nopix_w && slot_reg == `CTF_SLOT_NOPIX_X);
   wire y_slot_w   = (is_pix_w && slot_reg == `CTF_SLOT_PIX_Y) ||
                     (is_nopix_w && slot_reg == `CTF_SLOT_NOPIX_Y);
   wire e_slot_w   = (slot_reg == `CTF_SLOT_EXPO);
   wire t_slot_w   = (slot_reg == `CTF_SLOT_TYPE);
   wire [7:0] code_w = is_pix_w   ? `CTF_CODE_PIX :
                       is_nopix_w ? `CTF_CODE_NOPIX :
                                    `CTF_CODE_EMPTY;
   // A starved FIFO leaves a zero intensity rather than stalling the telemetry stream
   wire [7:0] z_data_w = fifo_rd_valid_w ? fifo_rd_data_w : `CTF_DATA_RST;
   wire [7:0] hold_next = own_w    ? `CTF_DATA_RST :
                          z_slot_w ? z_data_w :
                          x_slot_w ? addr_reg.x :
                          y_slot_w ? addr_reg.y :
                          e_slot_w ? expo_sync_reg :
                          t_slot_w ? code_w :
                                     `CTF_DATA_RST;
   wire load_w = load_pend_reg;
   assign fifo_pop_w = load_w && z_slot_w && fifo_rd_valid_w;

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         frame_reg      <= ctf_pkg::CTF_FRAME_EMPTY;
         addr_reg       <= '0;
         slot_reg       <= '0;
         load_pend_reg  <= 1'b0;
         frame_done_reg <= 1'b1;
      end else if (frame_rise) begin
         frame_reg      <= frame_next;
         addr_reg       <= addr_next;
         slot_reg       <= '0;
         load_pend_reg  <= 1'b1;
         frame_done_reg <= 1'b0;
      end else if (strobe_rise && !frame_done_reg) begin
         load_pend_reg  <= (slot_reg != `CTF_SLOT_LAST);
         frame_done_reg <= (slot_reg == `CTF_SLOT_LAST);
         slot_reg       <= slot_reg + 1'b1;
      end else begin
         load_pend_reg  <= 1'b0;
      end
   end

   // ==============================================
   // Holding register and telemetry bus
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_reg            <= `CTF_DATA_RST;
         tlm_data_out        <= `CTF_DATA_RST;
         tlm_slot_own_out    <= 1'b1;
         pixel_fetch_cmd_out <= 1'b0;
         frame_kind_out      <= ctf_pkg::CTF_FRAME_EMPTY;
      end else begin
         pixel_fetch_cmd_out <= load_w && z_slot_w;
         if (load_w) begin
            hold_reg <= hold_next;
         end
         if (strobe_rise && !frame_rise && !frame_done_reg) begin
            tlm_data_out     <= hold_reg;
            tlm_slot_own_out <= own_w;
            frame_kind_out   <= frame_reg;
         end
      end
   end

endmodule

`default_nettype wire

// >>> verif/ctf_formatter_props.sv
// Port assertions of the telemetry frame formatter
`timescale 1ns/1ns
`default_nettype none

module ctf_formatter_chk (
   input wire logic       ref_clk_in,
   input wire logic       rstn_in,
   input wire logic       convert_strobe_in,
   input wire logic       conversion_enable_in,
   input wire logic       active_pixel_window_in,
   input wire logic       frame_start_pulse_in,
   input wire logic       word_strobe_in,
   input wire logic [7:0] pixel_data_out,
   input wire logic       pixel_valid_out,
   input wire logic       pixel_fetch_cmd_out,
   input wire logic [7:0] tlm_data_out,
   input wire logic       tlm_slot_own_out,
   input wire logic [2:0] frame_kind_out
);
   // ====================
   // Edge age counters; they saturate so a long idle never wraps into a match
   logic [2:0] edge_q;
   logic [2:0] rise;
   logic [8:0] since_cvt;
   logic [7:0] since_word;
   logic [7:0] since_frame;
   assign rise = {convert_strobe_in, word_strobe_in, frame_start_pulse_in} & ~edge_q;

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         edge_q      <= 3'h7;
         since_cvt   <= 9'h1ff;
         since_word  <= 8'hff;
         since_frame <= 8'hff;
      end else begin
         edge_q      <= {convert_strobe_in, word_strobe_in, frame_start_pulse_in};
         since_cvt   <= rise[2] ? 9'h000 : since_cvt + {8'h00, since_cvt != 9'h1ff};
         since_word  <= rise[1] ? 8'h00 : since_word + {7'h00, since_word != 8'hff};
         since_frame <= rise[0] ? 8'h00 : since_frame + {7'h00, since_frame != 8'hff};
      end
   end

   // ====================
   // Assertions
   default clocking dclk @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_pix_start;
      (conversion_enable_in && active_pixel_window_in) [*4] ##0 $rose(frame_start_pulse_in);
   endsequence
   sequence s_idle_start;
      (!conversion_enable_in && !active_pixel_window_in) [*4] ##0 $rose(frame_start_pulse_in);
   endsequence

   AST_CVT_TIME: assert property ($rose(pixel_valid_out) |-> since_cvt inside {[398:399]})
      else $error("pixel result not timed from a convert strobe");
   AST_CVT_ANSWER: assert property ($rose(convert_strobe_in) && conversion_enable_in |->
      ##[1:400] ($rose(pixel_valid_out) || !conversion_enable_in)) else $error("conversion result late");
   AST_ENABLE_OFF: assert property (!conversion_enable_in [*5] |-> !pixel_valid_out)
      else $error("pixel valid while enable low");
   AST_VALID_HOLD: assert property (pixel_valid_out && $past(pixel_valid_out) |-> $stable(pixel_data_out))
      else $error("pixel data moved while valid");
   AST_OWN_ZERO: assert property (tlm_slot_own_out |-> tlm_data_out == 8'h00)
      else $error("data in a telemetry owned slot");
   AST_TLM_HOLD: assert property (!$stable(tlm_data_out) |-> since_word inside {[1:6]})
      else $error("telemetry word changed without a word strobe");
   AST_KIND_HOLD: assert property (!$stable(frame_kind_out) |-> since_frame < 8'h07 || since_word < 8'h07)
      else $error("frame kind changed outside a frame start");
   AST_KIND_CODE: assert property ($onehot(frame_kind_out))
      else $error("frame kind not one-hot");
   AST_KIND_PIX: assert property (s_pix_start |-> ##[1:40] frame_kind_out == 3'b100)
      else $error("pixel frame not chosen");
   AST_KIND_IDLE: assert property (s_idle_start |-> ##[1:40] frame_kind_out == 3'b001)
      else $error("empty frame not chosen");
   AST_FETCH: assert property (pixel_fetch_cmd_out |-> frame_kind_out == 3'b100 ##1 !pixel_fetch_cmd_out)
      else $error("fetch pulse outside a pixel frame or too long");
endmodule

bind ctf_formatter ctf_formatter_chk i_ctf_formatter_chk (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .convert_strobe_in(convert_strobe_in),
   .conversion_enable_in(conversion_enable_in), .active_pixel_window_in(active_pixel_window_in),
   .frame_start_pulse_in(frame_start_pulse_in), .word_strobe_in(word_strobe_in),
   .pixel_data_out(pixel_data_out), .pixel_valid_out(pixel_valid_out), .pixel_fetch_cmd_out(pixel_fetch_cmd_out),
   .tlm_data_out(tlm_data_out), .tlm_slot_own_out(tlm_slot_own_out), .frame_kind_out(frame_kind_out)
);

`default_nettype wire

// >>> verif/ctf_tlm_model.sv
// Telemetry system and camera clock generator model
`timescale 1ns/1ns
`default_nettype none

module ctf_tlm_model (
   input  wire logic       ref_clk_in,
   output logic            frame_start_pulse_out,
   output logic            word_strobe_out,
   output logic            convert_strobe_out,
   output logic            conversion_enable_out,
   output logic            active_pixel_window_out,
   output logic      [7:0] sample_level_out
);
   // ====================
   // Idle levels; the sample bus starts on a pattern, not on a result
   initial begin
      frame_start_pulse_out   = 1'b0;
      word_strobe_out         = 1'b0;
      convert_strobe_out      = 1'b0;
      conversion_enable_out   = 1'b0;
      active_pixel_window_out = 1'b0;
      sample_level_out        = 8'h5a;
   end

   // ====================
   // Camera state; window only opens with enable high, line length is not modelled
   task automatic mode(input logic en, input logic win);
      @(negedge ref_clk_in);
      conversion_enable_out   = en;
      active_pixel_window_out = win;
      repeat (4) @(negedge ref_clk_in);
   endtask

   // Level stays put until latched, then turns to its inverse
   task automatic convert(input logic [7:0] lvl);
      @(negedge ref_clk_in);
      sample_level_out   = lvl;
      convert_strobe_out = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      convert_strobe_out = 1'b0;
      sample_level_out   = ~lvl;
   endtask

   // ====================
   // Frame and word syncs; word period shortened so a run stays brief
   task automatic frame_start;
      @(negedge ref_clk_in);
      frame_start_pulse_out = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      frame_start_pulse_out = 1'b0;
      repeat (4) @(negedge ref_clk_in);
   endtask

   task automatic word;
      @(negedge ref_clk_in);
      word_strobe_out = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      word_strobe_out = 1'b0;
      repeat (4) @(negedge ref_clk_in);
   endtask
endmodule

`default_nettype wire

// >>> verif/ctf_formatter_tb_top.sv
// Self-checking testbench of the telemetry frame formatter
`timescale 1ns/1ns
`default_nettype none
`include "ctf_defs.svh"

module ctf_formatter_tb_top;
   logic       ref_clk;
   logic       rstn;
   logic [7:0] expo;
   logic       frame_start_pulse;
   logic       word_strobe;
   logic       convert_strobe;
   logic       conversion_enable;
   logic       active_pixel_window;
   logic [7:0] sample_level;
   logic [7:0] pixel_data;
   logic       pixel_valid;
   logic       pixel_fetch_cmd;
   logic [7:0] tlm_data;
   logic       tlm_slot_own;
   logic [2:0] frame_kind;
   logic [7:0] exp_w [0:31];
   logic [7:0] lv [0:8] = '{8'h80, 8'h00, 8'h7f, 8'h01, 8'hff, 8'h40, 8'hc0, 8'h22, 8'hdd};
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         n_fetch = 0;

   ctf_formatter #(.FIFO_DEPTH(`CTF_FIFO_DEPTH)) i_ctf_formatter (
      .ref_clk_in(ref_clk), .rstn_in(rstn), .convert_strobe_in(convert_strobe),
      .conversion_enable_in(conversion_enable), .active_pixel_window_in(active_pixel_window),
      .sample_level_in(sample_level), .exposure_filter_in(expo), .frame_start_pulse_in(frame_start_pulse),
      .word_strobe_in(word_strobe), .pixel_data_out(pixel_data), .pixel_valid_out(pixel_valid),
      .pixel_fetch_cmd_out(pixel_fetch_cmd), .tlm_data_out(tlm_data), .tlm_slot_own_out(tlm_slot_own),
      .frame_kind_out(frame_kind));

   ctf_tlm_model i_ctf_tlm_model (
      .ref_clk_in(ref_clk), .frame_start_pulse_out(frame_start_pulse), .word_strobe_out(word_strobe),
      .convert_strobe_out(convert_strobe), .conversion_enable_out(conversion_enable),
      .active_pixel_window_out(active_pixel_window), .sample_level_out(sample_level));

   // ====================
   // Clock, fetch pulse count and shared tasks
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (pixel_fetch_cmd === 1'b1) n_fetch++;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic set_frame(input logic [7:0] code, input int xs, input logic [7:0] x, input logic [7:0] y);
      foreach (exp_w[i]) exp_w[i] = 8'h00;
      exp_w[28] = expo;
      exp_w[31] = code;
      if (xs > 0) begin
         exp_w[xs]     = x;
         exp_w[xs + 1] = y;
      end
   endtask

   task automatic tlm_frame(input logic [2:0] kind);
      n_fetch = 0;
      i_ctf_tlm_model.frame_start();
      for (int s = 0; s < 32; s++) begin
         i_ctf_tlm_model.word();
         chk("tlm_data", tlm_data, exp_w[s]);
         chk("slot_own", {7'h00, tlm_slot_own}, {7'h00, s < 2});
         chk("frame_kind", {5'h00, frame_kind}, {5'h00, kind});
      end
      chk("fetch_count", n_fetch[7:0], (kind == 3'b100) ? 8'h08 : 8'h00);
   endtask

   // ====================
   // Scenarios
   task automatic t_reset;
      chk("reset_flags", {2'b00, pixel_valid, pixel_fetch_cmd, tlm_slot_own, frame_kind}, 8'h09);
      chk("reset_data", pixel_data | tlm_data, 8'h00);
   endtask

   task automatic t_empty;
      expo = 8'ha5;
      i_ctf_tlm_model.mode(1'b0, 1'b0);
      set_frame(`CTF_CODE_EMPTY, 0, 8'h00, 8'h00);
      tlm_frame(3'b001);
   endtask

   // Line count rises as each window closes, so Y names the next line
   task automatic t_nopix(input logic [7:0] y);
      expo = 8'h3c;
      i_ctf_tlm_model.mode(1'b1, 1'b0);
      set_frame(`CTF_CODE_NOPIX, 2, 8'h00, y);
      tlm_frame(3'b010);
   endtask

   // Nine results queue up: one more than a frame carries
   task automatic t_convert;
      int n;
      i_ctf_tlm_model.mode(1'b1, 1'b1);
      foreach (lv[i]) begin
         i_ctf_tlm_model.convert(lv[i]);
         n = 0;
         while (pixel_valid !== 1'b1 && n < 420) begin
            @(negedge ref_clk);
            n++;
         end
         chk("convert_time", {7'h00, n < 397}, 8'h01);
         chk("pixel_data", pixel_data, lv[i] ^ 8'h80);
         repeat (3) @(negedge ref_clk);
         chk("pixel_hold", {pixel_valid, pixel_data[6:0]}, {1'b1, lv[i][6:0]});
      end
   endtask

   task automatic t_pixel;
      set_frame(`CTF_CODE_PIX, 3, 8'h00, 8'h00);
      for (int i = 0; i < 8; i++) begin
         exp_w[2 + 4 * i] = lv[i] ^ 8'h80;
      end
      tlm_frame(3'b100);
      set_frame(`CTF_CODE_PIX, 3, 8'h08, 8'h00);
      exp_w[2] = lv[8] ^ 8'h80;
      tlm_frame(3'b100);
   endtask

   task automatic t_disable;
      i_ctf_tlm_model.mode(1'b0, 1'b0);
      chk("valid_off", {7'h00, pixel_valid}, 8'h00);
      i_ctf_tlm_model.convert(8'h11);
      repeat (420) @(negedge ref_clk);
      chk("valid_off", {7'h00, pixel_valid}, 8'h00);
   endtask

   // ====================
   // Verdict, sequence and watchdog
   task automatic end_of_test;
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      expo = 8'h00;
      repeat (2) @(negedge ref_clk);
      rstn = 1'b1;
      t_reset();
      t_empty();
      t_nopix(8'h00);
      t_convert();
      t_pixel();
      t_nopix(8'h01);
      t_disable();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      end_of_test();
   end
endmodule

`default_nettype wire
